// file: logic/rws_pkg.sv
package rws_pkg;
  localparam int CLK_HZ = 10_000_000;
  // Oscillator tick rate feeding the watchdog and reset delay timers
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int RESET_FILTER_TIME_US = 10;
  localparam int RESET_FILTER_CYC = (RESET_FILTER_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    RESET_FILTER_TIME_US * (CLK_HZ / 1_000_000);
  localparam int RESET_DELAY_FIRST_MS = 10;
  localparam int RESET_DELAY_SECOND_MS = 2;
  localparam int LONG_OPEN_WINDOW_TIME_MS = 200;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int RESET_DELAY_FIRST_TICKS = RESET_DELAY_FIRST_MS * TICKS_PER_MS;
  localparam int RESET_DELAY_SECOND_TICKS = RESET_DELAY_SECOND_MS * TICKS_PER_MS;
  localparam int LONG_OPEN_WINDOW_TICKS = LONG_OPEN_WINDOW_TIME_MS * TICKS_PER_MS;
  localparam int CLOSED_PERCENT = 60;
  localparam int TIMER_W = 20;

  // Register map, byte offsets, four bytes per word
  localparam logic [7:0] MODE_CTRL_ADDR = 8'h00;
  localparam logic [7:0] WDOG_CTRL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] CONFIG_ADDR = 8'h0C;

  localparam logic [1:0] MODE_FIELD_LSB_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CMD_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CMD_STOP = 2'h2;
  localparam logic [1:0] MODE_CMD_SOFT_RESET = 2'h3;

  // Watchdog control word field positions
  localparam int WDC_PERIOD_LSB = 0;
  localparam int WDC_TYPE_BIT = 3;
  localparam int WDC_FAILSAFE_BIT = 4;
  localparam int WDC_SWDEV_BIT = 5;
  localparam int WDC_CHECKSUM_BIT = 15;
  localparam logic [15:0] WDOG_CTRL_RESET = 16'h0000;

  localparam int CFG_DELAY_BIT = 0;
  localparam int CFG_SUPPRESS_BIT = 1;

  // Periods in ms for settings 0..7
  localparam int PERIOD_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

  typedef enum logic [5:0] {
    RWS_INIT = 6'h01,
    RWS_NORMAL = 6'h02,
    RWS_STOP = 6'h04,
    RWS_SLEEP = 6'h08,
    RWS_RESTART = 6'h10,
    RWS_FAILSAFE = 6'h20
  } rws_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rws_bus_req_t;
endpackage

// file: logic/rws_supervisor.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Reset event pulls reset low after filter, held during event plus selected delay.
// - At power-up reset stays low until regulator good, then first delay.
// - Watchdog trigger failure counts as a reset event.
// - Mode field value 11 requests soft reset: Init Mode, registers default.
// - Soft reset outside Normal or Stop Mode is ignored.
// - Suppress bit 0: soft reset pulses reset output; bit 1: output untouched.
// - Type bit selects time-out watchdog (default) or window watchdog.
// - Watchdog setup writable only in Normal Mode, kept in Stop Mode.
// - Long open window after reset release; off in Sleep and Restart.
// - Valid watchdog control write serves and restarts timer, with new setting in Normal Mode only.
// - Period field picks one of eight periods for both watchdog types.
// - Watchdog reset sets failure bits, Restart or Fail-Safe, then Normal.
// - In software development mode a miss restarts the long open window.
// - Failure bits clear after good trigger, soft reset or in Sleep Mode.
// - Time-out mode accepts trigger anywhere in period, restarting period.
// - Time-out expiry drives reset low and enters Restart or Fail-Safe.
// - Window mode: closed window of 60 percent, then open window.
// - Window mode good trigger starts next closed window immediately.
// - Early trigger or expiry in window mode causes watchdog reset.
// - Watchdog write with odd parity ignored and sets failure flag.
module rws_supervisor
  import rws_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DELAY_FIRST_TICKS = RESET_DELAY_FIRST_TICKS,
  parameter int DELAY_SECOND_TICKS = RESET_DELAY_SECOND_TICKS,
  parameter int LONG_WINDOW_TICKS = LONG_OPEN_WINDOW_TICKS,
  parameter int PERIOD_SCALE = TICKS_PER_MS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic regulator_ok,
  input wire rws_pkg::rws_bus_req_t bus_req,
  output logic [15:0] rdata,
  output logic host_reset_out_n,
  output rws_pkg::rws_mode_t mode
);
  import rws_pkg::*;

  // Window expiry sits at 1.4 times the longest period
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536 || DELAY_FIRST_TICKS < 1 ||
      DELAY_SECOND_TICKS < 1 || LONG_WINDOW_TICKS < 1 || PERIOD_SCALE < 1 ||
      LONG_WINDOW_TICKS >= (1 << TIMER_W) ||
      10000 * PERIOD_SCALE * 14 / 10 >= (1 << TIMER_W)) begin : g_param_check
    $error("rws_supervisor: parameter out of range");
  end

  // Regulator good comes from the analog domain
  logic [2:0] reg_ok_sync;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ok_sync <= 3'h0;
    end else if (clk_en) begin
      reg_ok_sync <= {reg_ok_sync[1:0], regulator_ok};
    end
  end
  logic reg_ok_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ok_reg <= 1'b0;
    end else if (clk_en && (reg_ok_sync[2] == reg_ok_sync[1])) begin
      reg_ok_reg <= reg_ok_sync[2];
    end
  end

  // Oscillator tick
  logic [15:0] tick_cnt_reg;
  logic tick;
  assign tick = clk_en && (tick_cnt_reg == 16'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // Registers
  logic [15:0] wdog_control_reg;
  logic reset_release_delay_sel;
  logic soft_reset_pin_suppress;
  logic wdog_failure_bits;
  logic spi_fail_reg;
  logic wdog_type_select;
  logic [2:0] wdog_period_select;
  assign wdog_type_select = wdog_control_reg[WDC_TYPE_BIT];
  assign wdog_period_select = wdog_control_reg[WDC_PERIOD_LSB +: 3];

  logic wd_wr, wd_parity_ok, wd_valid, mode_wr, soft_reset, soft_reset_pin;
  assign wd_wr = clk_en && bus_req.wr && (bus_req.addr == WDOG_CTRL_ADDR);
  assign wd_parity_ok = ~^bus_req.wdata;
  assign wd_valid = wd_wr && wd_parity_ok && (mode == RWS_NORMAL || mode == RWS_STOP);
  assign mode_wr = clk_en && bus_req.wr && (bus_req.addr == MODE_CTRL_ADDR);
  assign soft_reset = mode_wr && (bus_req.wdata[1:0] == MODE_CMD_SOFT_RESET) &&
    (mode == RWS_NORMAL || mode == RWS_STOP);
  assign soft_reset_pin = soft_reset && !soft_reset_pin_suppress;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_control_reg <= WDOG_CTRL_RESET;
    end else if (soft_reset) begin
      wdog_control_reg <= WDOG_CTRL_RESET;
    end else if (wd_valid && mode == RWS_NORMAL) begin
      wdog_control_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_release_delay_sel <= 1'b0;
      soft_reset_pin_suppress <= 1'b0;
    end else if (soft_reset) begin
      reset_release_delay_sel <= 1'b0;
      soft_reset_pin_suppress <= 1'b0;
    end else if (clk_en && bus_req.wr && bus_req.addr == CONFIG_ADDR) begin
      reset_release_delay_sel <= bus_req.wdata[CFG_DELAY_BIT];
      soft_reset_pin_suppress <= bus_req.wdata[CFG_SUPPRESS_BIT];
    end
  end

  // Set wins over the software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_fail_reg <= 1'b0;
    end else if (wd_wr && !wd_parity_ok) begin
      spi_fail_reg <= 1'b1;
    end else if (soft_reset) begin
      spi_fail_reg <= 1'b0;
    end else if (clk_en && bus_req.wr && bus_req.addr == STATUS_ADDR && bus_req.wdata[1]) begin
      spi_fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      if (!bus_req.rd) begin
        rdata <= 16'h0000;
      end else if (bus_req.addr == MODE_CTRL_ADDR) begin
        rdata <= {10'h000, mode};
      end else if (bus_req.addr == WDOG_CTRL_ADDR) begin
        rdata <= wdog_control_reg;
      end else if (bus_req.addr == STATUS_ADDR) begin
        rdata <= {13'h0000, host_reset_out_n, spi_fail_reg, wdog_failure_bits};
      end else if (bus_req.addr == CONFIG_ADDR) begin
        rdata <= {14'h0000, soft_reset_pin_suppress, reset_release_delay_sel};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // Watchdog timer
  logic [TIMER_W-1:0] period_ticks, closed_ticks, limit_ticks;
  always_comb begin
    period_ticks = TIMER_W'(PERIOD_MS[wdog_period_select] * PERIOD_SCALE);
    closed_ticks = TIMER_W'(PERIOD_MS[wdog_period_select] * PERIOD_SCALE *
      CLOSED_PERCENT / 100);
    // Window mode open window ends symmetric about nominal period
    limit_ticks = wdog_type_select ? TIMER_W'(period_ticks + period_ticks - closed_ticks) :
      period_ticks;
  end

  logic [TIMER_W-1:0] wd_cnt_reg;
  logic long_win_reg, wd_run;
  assign wd_run = (mode == RWS_NORMAL || mode == RWS_STOP) && host_reset_out_n;
  logic wd_early, wd_expire, wd_fault, wd_good;
  assign wd_early = wd_valid && !long_win_reg && wdog_type_select &&
    (wd_cnt_reg < closed_ticks);
  assign wd_expire = wd_run && tick &&
    (wd_cnt_reg >= (long_win_reg ? TIMER_W'(LONG_WINDOW_TICKS - 1) : limit_ticks - 1'b1));
  assign wd_good = wd_valid && !wd_early;
  logic swdev;
  assign swdev = wdog_control_reg[WDC_SWDEV_BIT];
  assign wd_fault = wd_run && (wd_early || wd_expire) && !swdev;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_reg <= '0;
      long_win_reg <= 1'b1;
    end else if (clk_en) begin
      if (!wd_run) begin
        wd_cnt_reg <= '0;
        long_win_reg <= 1'b1;
      end else if (wd_good) begin
        wd_cnt_reg <= '0;
        long_win_reg <= 1'b0;
      end else if (wd_early || wd_expire) begin
        wd_cnt_reg <= '0;
        long_win_reg <= 1'b1;
      end else if (tick) begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_failure_bits <= 1'b0;
    end else if (clk_en) begin
      if (wd_fault) begin
        wdog_failure_bits <= 1'b1;
      end else if (wd_good || mode == RWS_SLEEP || soft_reset) begin
        wdog_failure_bits <= 1'b0;
      end
    end
  end

  // Reset output sequencing
  logic [15:0] filt_cnt_reg;
  logic [TIMER_W-1:0] delay_cnt_reg;
  logic hold_reg, uv_event, filt_done;
  assign uv_event = !reg_ok_reg;
  assign filt_done = filt_cnt_reg >= 16'(RESET_FILTER_CYC);
  logic [TIMER_W-1:0] delay_ticks;
  // Select is latched at the event, since a soft reset clears the live one
  logic delay_sel_reg;
  assign delay_ticks = delay_sel_reg ? TIMER_W'(DELAY_SECOND_TICKS) :
    TIMER_W'(DELAY_FIRST_TICKS);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!uv_event) begin
        filt_cnt_reg <= 16'h0000;
      end else if (!filt_done) begin
        filt_cnt_reg <= filt_cnt_reg + 16'h0001;
      end
    end
  end

  // Power-on starts held low with first delay pending
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= 1'b1;
      delay_cnt_reg <= '0;
      host_reset_out_n <= 1'b0;
      delay_sel_reg <= 1'b0;
    end else if (clk_en) begin
      if ((uv_event && (filt_done || !host_reset_out_n)) || wd_fault || soft_reset_pin) begin
        hold_reg <= 1'b1;
        delay_sel_reg <= reset_release_delay_sel;
        delay_cnt_reg <= '0;
        host_reset_out_n <= 1'b0;
      end else if (hold_reg) begin
        if (tick) begin
          if (delay_cnt_reg >= delay_ticks - 1'b1) begin
            hold_reg <= 1'b0;
            host_reset_out_n <= 1'b1;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 1'b1;
          end
        end
      end
    end
  end

  // Mode sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= RWS_INIT;
    end else if (clk_en) begin
      if (soft_reset) begin
        mode <= RWS_INIT;
      end else if (wd_fault) begin
        mode <= wdog_control_reg[WDC_FAILSAFE_BIT] ? RWS_FAILSAFE : RWS_RESTART;
      end else begin
        case (mode)
          RWS_INIT, RWS_RESTART, RWS_FAILSAFE: begin
            if (host_reset_out_n) begin
              mode <= RWS_NORMAL;
            end
          end
          RWS_NORMAL, RWS_STOP: begin
            if (mode_wr && bus_req.wdata[1:0] == MODE_CMD_SLEEP) begin
              mode <= RWS_SLEEP;
            end else if (mode_wr && bus_req.wdata[1:0] == MODE_CMD_STOP) begin
              mode <= RWS_STOP;
            end else if (mode_wr && bus_req.wdata[1:0] == MODE_CMD_NORMAL) begin
              mode <= RWS_NORMAL;
            end
          end
          default: begin
            if (mode_wr && bus_req.wdata[1:0] == MODE_CMD_NORMAL) begin
              mode <= RWS_NORMAL;
            end
          end
        endcase
      end
    end
  end

  pwr_release_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(host_reset_out_n) |-> $past(reg_ok_reg));
  fault_pulls_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    wd_fault |=> !host_reset_out_n);
  soft_ignored_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_wr && bus_req.wdata[1:0] == MODE_CMD_SOFT_RESET && mode == RWS_SLEEP) |=>
    mode == RWS_SLEEP);
  soft_suppress_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (soft_reset && soft_reset_pin_suppress && host_reset_out_n && !uv_event) |=>
    host_reset_out_n);
  cfg_lock_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode == RWS_STOP && !soft_reset) |=> $stable(wdog_control_reg));
  parity_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wd_wr && !wd_parity_ok) |=> spi_fail_reg && $stable(wdog_control_reg));
  fail_mode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wd_fault && !soft_reset) |=> (mode == RWS_RESTART || mode == RWS_FAILSAFE) &&
    wdog_failure_bits);
  early_fault_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wd_run && wd_early && !swdev) |=> !host_reset_out_n);
  good_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wd_good && wd_run && !wd_expire) |=> !wdog_failure_bits);
endmodule

// file: verif/rws_host_model.sv
`timescale 1ns/1ps
module rws_host_model
  import rws_pkg::*;
(
  input wire logic core_clk,
  output rws_pkg::rws_bus_req_t bus_req,
  input wire logic [15:0] rdata
);
  initial bus_req = '0;

  // Strobe rises after one edge and drops after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge core_clk);
    bus_req.wr <= 1'h0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
    @(posedge core_clk);
    bus_req.rd <= 1'h0;
    @(negedge core_clk);
    d = rdata;
  endtask

  // Reserved bits count towards the parity too
  function automatic logic [15:0] sealed(input logic [15:0] d);
    return {^d[14:0], d[14:0]};
  endfunction

  task automatic serve(input logic [15:0] d);
    wr(WDOG_CTRL_ADDR, sealed(d));
  endtask

  // Spacing between services; a write adds two cycles to the gap
  task automatic window_gap(input int per);
    repeat (per * 3 / 4 + $urandom_range(0, per * 3 / 8) - 2) @(posedge core_clk);
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rws_pkg::*;
  localparam int TC = 2;
  logic core_clk;
  logic arst_n;
  logic regulator_ok;
  rws_bus_req_t bus_req;
  logic [15:0] rdata;
  logic [15:0] d;
  logic host_reset_out_n;
  rws_mode_t mode;
  int miscompares = 0;
  int n_compared = 0;
  int s;

  rws_supervisor #(.TICK_CYCLES(TC), .DELAY_FIRST_TICKS(3), .DELAY_SECOND_TICKS(2),
    .LONG_WINDOW_TICKS(20), .PERIOD_SCALE(1)) i_rws_supervisor (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(1'h1), .regulator_ok(regulator_ok),
    .bus_req(bus_req), .rdata(rdata), .host_reset_out_n(host_reset_out_n), .mode(mode));
  rws_host_model i_rws_host_model (.core_clk(core_clk), .bus_req(bus_req), .rdata(rdata));

  function automatic logic [15:0] stat_exp(input logic fail, input logic spi, input logic rst);
    return {13'h0000, rst, spi, fail};
  endfunction
  function automatic int per_cyc(input int sel);
    return PERIOD_MS[sel] * TC;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic chk_mode(input rws_mode_t m);
    chk({10'h000, mode}, {10'h000, m});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    i_rws_host_model.rd(a, d);
    chk(d & m, e);
  endtask
  // Let the taking edge's updates land before anything is sampled
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    i_rws_host_model.wr(a, v);
    @(negedge core_clk);
  endtask
  task automatic sv(input logic [15:0] v);
    i_rws_host_model.serve(v);
    @(negedge core_clk);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    for (int k = 0; k < lim && host_reset_out_n !== lvl; k++) @(negedge core_clk);
    chk({15'h0000, host_reset_out_n}, {15'h0000, lvl});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // Whole run is under two thousand cycles
  initial begin
    cyc(20000);
    miscompares++;
    close_out();
  end

  initial begin
    s = $urandom(32'hDDCD);
    arst_n = 1'h0;
    regulator_ok = 1'h0;
    cyc(20);
    chk_mode(RWS_INIT);
    arst_n <= 1'h1;
    cyc(60);
    chk({15'h0000, host_reset_out_n}, 16'h0000);
    regulator_ok <= 1'h1;
    wait_rst(1'h1, 40);
    rchk(STATUS_ADDR, 16'hFFFF, stat_exp(0, 0, 1));
    rchk(WDOG_CTRL_ADDR, 16'hFFFF, WDOG_CTRL_RESET);
    rchk(CONFIG_ADDR, 16'hFFFF, 16'h0000);
    rchk(8'h10, 16'hFFFF, 16'h0000);
    wr(MODE_CTRL_ADDR, 16'h0000);
    chk_mode(RWS_NORMAL);
    wr(MODE_CTRL_ADDR, {14'h0000, MODE_CMD_SLEEP});
    wr(MODE_CTRL_ADDR, {14'h0000, MODE_CMD_SOFT_RESET});
    chk_mode(RWS_SLEEP);
    // Short dip outlasts the long window too: watchdog must stay off
    regulator_ok <= 1'h0;
    cyc(50);
    regulator_ok <= 1'h1;
    cyc(10);
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    regulator_ok <= 1'h0;
    cyc(90);
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    wait_rst(1'h0, 25);
    cyc(30);
    chk({15'h0000, host_reset_out_n}, 16'h0000);
    regulator_ok <= 1'h1;
    wait_rst(1'h1, 30);
    wr(MODE_CTRL_ADDR, 16'h0000);
    chk_mode(RWS_NORMAL);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6; k++) begin
        sv({13'h0000, 3'(p)});
        cyc($urandom_range(1, per_cyc(p) - 6));
      end
      sv({13'h0000, 3'(p)});
      cyc(per_cyc(p) - 5);
      chk({15'h0000, host_reset_out_n}, 16'h0001);
      wait_rst(1'h0, 12);
      chk_mode(RWS_RESTART);
      wait_rst(1'h1, 40);
      @(negedge core_clk);
      chk_mode(RWS_NORMAL);
      rchk(STATUS_ADDR, 16'h0001, 16'h0001);
      sv({13'h0000, 3'(p)});
      rchk(STATUS_ADDR, 16'h0001, 16'h0000);
    end
    for (int p = 0; p < 8; p++) begin
      sv({13'h0000, 3'(p)});
      rchk(WDOG_CTRL_ADDR, 16'h7FFF, {13'h0000, 3'(p)});
    end
    wr(WDOG_CTRL_ADDR, 16'h0001);
    rchk(STATUS_ADDR, 16'h0002, 16'h0002);
    rchk(WDOG_CTRL_ADDR, 16'h7FFF, 16'h0007);
    wr(STATUS_ADDR, 16'h0002);
    rchk(STATUS_ADDR, 16'h0002, 16'h0000);
    wr(MODE_CTRL_ADDR, {14'h0000, MODE_CMD_STOP});
    chk_mode(RWS_STOP);
    sv(16'h0008);
    rchk(WDOG_CTRL_ADDR, 16'h7FFF, 16'h0007);
    wr(MODE_CTRL_ADDR, 16'h0000);
    sv(16'h0008);
    for (int k = 0; k < 6; k++) begin
      i_rws_host_model.window_gap(per_cyc(0));
      sv(16'h0008);
    end
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    i_rws_host_model.window_gap(per_cyc(0));
    sv(16'h0018);
    cyc(3);
    sv(16'h0018);
    wait_rst(1'h0, 4);
    chk_mode(RWS_FAILSAFE);
    wait_rst(1'h1, 40);
    @(negedge core_clk);
    chk_mode(RWS_NORMAL);
    wr(CONFIG_ADDR, 16'h0002);
    wr(MODE_CTRL_ADDR, {14'h0000, MODE_CMD_SOFT_RESET});
    chk_mode(RWS_INIT);
    cyc(10);
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    rchk(CONFIG_ADDR, 16'hFFFF, 16'h0000);
    rchk(WDOG_CTRL_ADDR, 16'hFFFF, WDOG_CTRL_RESET);
    wr(MODE_CTRL_ADDR, 16'h0000);
    wr(CONFIG_ADDR, 16'h0001);
    wr(MODE_CTRL_ADDR, {14'h0000, MODE_CMD_SOFT_RESET});
    wait_rst(1'h0, 4);
    chk_mode(RWS_INIT);
    // Second delay must have run out, the first one not yet
    repeat (4) @(negedge core_clk);
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    wait_rst(1'h1, 30);
    // Misses in development mode only reopen the long window
    sv(16'h0020);
    cyc(100);
    chk({15'h0000, host_reset_out_n}, 16'h0001);
    chk_mode(RWS_NORMAL);
    rchk(STATUS_ADDR, 16'h0001, 16'h0000);
    close_out();
  end
endmodule
